/* File: src/fes_exception_unit.sv */
`timescale 1ns/100ps
module fes_exception_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Instruction issue from the CPU pipeline
   input wire logic issueValid,
   input wire fes_pkg::fes_op_t issueOp,
   input wire logic [4:0] issueFmt,
   input wire logic [31:0] issueOperand,
   input wire logic [5:0] issueExc,
   input wire logic issueDenormResult,
   input wire logic issueCompareTrue,
   // Control register moves
   input wire logic ctrlWrite,
   input wire logic [31:0] ctrlWriteData,
   // Status and results
   output logic [31:0] csrReadData,
   output logic fpTrap,
   output logic resultWrite,
   output logic unimplTrap,
   output logic branchTaken,
   output logic [1:0] roundMode,
   output logic flushToZero,
   output logic operandSigNan
);
   import fes_pkg::*;
   logic rstSync1;
   logic rstnSync;
   logic [31:0] csr_reg;
   logic [5:0] causeNext;
   logic [4:0] enables;
   logic trapNow;
   logic flushed;
   fes_if decBus ();
   assign decBus.op = issueOp;
   assign decBus.fmt = issueFmt;
   assign decBus.operand = issueOperand;
   fes_format_check uCheck (
      .dec(decBus)
   );
   // Reset released through two stages so that release is clean against clk.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstSync1 <= 1'b0;
         rstnSync <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstnSync <= rstSync1;
      end
   end
   assign enables = csr_reg[ENABLE_LSB +: 5];
   // A flushed denormal hides the emulation request.
   assign flushed = issueDenormResult && csr_reg[FLUSH_BIT];
   always_comb begin
      causeNext = issueExc;
      causeNext[EXC_UNIMPL] = decBus.unimpl || (issueDenormResult && !csr_reg[FLUSH_BIT]);
      if (flushed) begin
         causeNext[EXC_UNIMPL] = decBus.unimpl;
      end
   end
   // Unimplemented always traps; others trap only when enabled.
   assign trapNow = issueValid && decBus.isFpOp
      && (causeNext[EXC_UNIMPL] || |(causeNext[4:0] & enables));
   // Control/status register update.
   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         csr_reg <= CSR_RESET;
      end else if (ctrlWrite) begin
         // Explicit writes own every field, flags included.
         csr_reg <= ctrlWriteData & CSR_WRITABLE;
      end else if (issueValid && decBus.isFpOp) begin
         csr_reg[CAUSE_LSB +: 6] <= causeNext;
         if (!trapNow) begin
            // Sticky flags gather only untrapped conditions.
            csr_reg[FLAG_LSB +: 5] <= csr_reg[FLAG_LSB +: 5] | causeNext[4:0];
            if (issueOp == OP_COMPARE) begin
               csr_reg[COND_BIT] <= issueCompareTrue;
            end
         end
      end else if (issueValid && decBus.unimpl) begin
         // Doubleword transfers only report emulation; other transfers leave cause.
         csr_reg[CAUSE_LSB + EXC_UNIMPL] <= 1'b1;
      end
   end
   // Trap output: operation, doubleword transfer or control write with the unimpl cause or an enabled cause.
   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         fpTrap <= 1'b0;
         unimplTrap <= 1'b0;
      end else begin
         fpTrap <= trapNow
            || (issueValid && !decBus.isFpOp && decBus.unimpl)
            || (ctrlWrite && (ctrlWriteData[CAUSE_LSB + EXC_UNIMPL]
            || |(ctrlWriteData[CAUSE_LSB +: 5] & ctrlWriteData[ENABLE_LSB +: 5])));
         unimplTrap <= issueValid && causeNext[EXC_UNIMPL] && (decBus.isFpOp || decBus.unimpl);
      end
   end
   // Result store suppressed on a trap; default result kept otherwise.
   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         resultWrite <= 1'b0;
         branchTaken <= 1'b0;
         operandSigNan <= 1'b0;
      end else begin
         resultWrite <= issueValid && !decBus.unimpl && !trapNow
            && issueOp != OP_COMPARE && issueOp != OP_BRANCH
            && issueOp != OP_CTRL_TO && issueOp != OP_STORE_WORD;
         // Format field of a branch carries the sense: nonzero means branch on true.
         branchTaken <= issueValid && issueOp == OP_BRANCH
            && (csr_reg[COND_BIT] == (issueFmt != 5'h00));
         operandSigNan <= issueValid && decBus.sigNan;
      end
   end
   // Read port mirrors the register with no side effect.
   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         csrReadData <= CSR_RESET;
         roundMode <= RND_NEAREST_EVEN;
         flushToZero <= 1'b0;
      end else begin
         csrReadData <= csr_reg;
         roundMode <= csr_reg[RMODE_LSB +: 2];
         flushToZero <= csr_reg[FLUSH_BIT];
      end
   end
   a_flags_sticky: assert property (@(posedge clk) disable iff (!rstnSync)
      !ctrlWrite |=> (csr_reg[FLAG_LSB +: 5] & $past(csr_reg[FLAG_LSB +: 5]))
      == $past(csr_reg[FLAG_LSB +: 5])) else $error("flag cleared without write");
   a_trap_no_result: assert property (@(posedge clk) disable iff (!rstnSync)
      trapNow |=> fpTrap && !resultWrite) else $error("result stored on trap");
   a_unimpl_traps: assert property (@(posedge clk) disable iff (!rstnSync)
      issueValid && decBus.unimpl |=> fpTrap && unimplTrap) else $error("unimpl not trapped");
   a_trap_keeps_flags: assert property (@(posedge clk) disable iff (!rstnSync)
      trapNow && !ctrlWrite |=> $stable(csr_reg[FLAG_LSB +: 5])) else $error("flags moved on trap");
   a_cause_written: assert property (@(posedge clk) disable iff (!rstnSync)
      issueValid && decBus.isFpOp && !ctrlWrite |=> csr_reg[CAUSE_LSB +: 6] == $past(causeNext))
      else $error("cause not rewritten");
   a_load_no_trap: assert property (@(posedge clk) disable iff (!rstnSync)
      issueValid && issueOp == OP_LOAD_WORD && !ctrlWrite |=> !fpTrap
      && $stable(csr_reg[CAUSE_LSB +: 6])) else $error("word load touched cause");
   a_double_trap: assert property (@(posedge clk) disable iff (!rstnSync)
      issueValid && issueOp == OP_ARITH && issueFmt == FMT_DOUBLE |=> unimplTrap)
      else $error("double arithmetic accepted");
   a_cond_hold: assert property (@(posedge clk) disable iff (!rstnSync)
      !ctrlWrite && !(issueValid && issueOp == OP_COMPARE) |=> $stable(csr_reg[COND_BIT]))
      else $error("condition bit changed");
   a_round_out: assert property (@(posedge clk) disable iff (!rstnSync)
      ##1 roundMode == $past(csr_reg[1:0])) else $error("round mode mismatch");
endmodule // fes_exception_unit

/* File: src/fes_format_check.sv */
`timescale 1ns/100ps
module fes_format_check (
   // Decoded instruction
   fes_if.checker_side dec
);
   import fes_pkg::*;
   logic fmtSingle;
   logic fmtDouble;
   logic fmtLong;
   logic [7:0] expField;
   logic [22:0] fracField;
   // Format field decode.
   assign fmtSingle = (dec.fmt == FMT_SINGLE);
   assign fmtDouble = (dec.fmt == FMT_DOUBLE);
   assign fmtLong = (dec.fmt == FMT_LONG);
   assign expField = dec.operand[30:23];
   assign fracField = dec.operand[22:0];
   always_comb begin
      dec.unimpl = 1'b0;
      dec.isFpOp = 1'b0;
      case (dec.op)
         OP_ARITH, OP_ABS, OP_MOVE, OP_NEG, OP_SQRT: begin
            dec.isFpOp = 1'b1;
            dec.unimpl = !fmtSingle;
         end
         OP_COMPARE: begin
            dec.isFpOp = 1'b1;
            dec.unimpl = fmtDouble || fmtLong;
         end
         OP_CVT_SINGLE, OP_CVT_WORD, OP_ROUND_WORD: begin
            dec.isFpOp = 1'b1;
            dec.unimpl = fmtDouble || fmtLong;
         end
         OP_CVT_DOUBLE, OP_CVT_LONG, OP_ROUND_LONG: begin
            dec.isFpOp = 1'b1;
            dec.unimpl = 1'b1;
         end
         OP_LOAD_DWORD, OP_STORE_DWORD, OP_MOVE_DWORD: begin
            dec.unimpl = 1'b1;
         end
         default: begin
            dec.unimpl = 1'b0;
         end
      endcase
   end
   // Operand classification.
   always_comb begin
      if (expField == EXP_ALL_ONES) begin
         dec.opClass = (fracField == '0) ? CLS_INF : CLS_NAN;
      end else if (expField == 8'h00) begin
         dec.opClass = CLS_ZERO;
      end else begin
         dec.opClass = CLS_NORMAL;
      end
   end
   assign dec.sigNan = (dec.opClass == CLS_NAN) && fracField[22];
endmodule // fes_format_check

/* File: src/fes_if.sv */
`timescale 1ns/100ps
// Decoded instruction handed from the top module to its format checker.
interface fes_if;
   import fes_pkg::*;
   fes_op_t op;
   logic [4:0] fmt;
   logic [31:0] operand;
   logic unimpl;
   logic isFpOp;
   fes_class_t opClass;
   logic sigNan;
   modport master (output op, fmt, operand, input unimpl, isFpOp, opClass, sigNan);
   modport checker_side (input op, fmt, operand, output unimpl, isFpOp, opClass, sigNan);
endinterface

/* File: src/fes_pkg.sv */
package fes_pkg;
   localparam int CAUSE_LSB = 12;
   localparam int ENABLE_LSB = 7;
   localparam int FLAG_LSB = 2;
   localparam int COND_BIT = 23;
   localparam int FLUSH_BIT = 24;
   localparam int RMODE_LSB = 0;
   localparam logic [31:0] CSR_RESET = 32'h0000_0000;
   localparam logic [31:0] CSR_WRITABLE = 32'h0183_ffff;
   // Cause bit order, low to high: inexact, underflow, overflow, divide, invalid, unimpl.
   localparam int EXC_UNIMPL = 5;
   localparam logic [1:0] RND_NEAREST_EVEN = 2'h0;
   localparam logic [1:0] RND_TOWARD_ZERO = 2'h1;
   localparam logic [1:0] RND_TOWARD_POS_INF = 2'h2;
   localparam logic [1:0] RND_TOWARD_NEG_INF = 2'h3;
   localparam int EXP_WIDTH = 8;
   localparam int FRAC_WIDTH = 23;
   localparam int EXP_BIAS = 127;
   localparam logic [7:0] EXP_ALL_ONES = 8'hff;
   // Format field codes of the instruction word.
   localparam logic [4:0] FMT_SINGLE = 5'h10;
   localparam logic [4:0] FMT_DOUBLE = 5'h11;
   localparam logic [4:0] FMT_WORD = 5'h14;
   localparam logic [4:0] FMT_LONG = 5'h15;
   typedef enum logic [4:0] {
      OP_NONE, OP_ARITH, OP_ABS, OP_MOVE, OP_NEG, OP_SQRT, OP_COMPARE,
      OP_CVT_SINGLE, OP_CVT_DOUBLE, OP_CVT_WORD, OP_CVT_LONG, OP_ROUND_WORD,
      OP_ROUND_LONG, OP_LOAD_WORD, OP_STORE_WORD, OP_LOAD_DWORD, OP_STORE_DWORD,
      OP_MOVE_WORD, OP_MOVE_DWORD, OP_CTRL_TO, OP_CTRL_FROM, OP_BRANCH
   } fes_op_t;
   typedef enum logic [1:0] {CLS_ZERO, CLS_NORMAL, CLS_INF, CLS_NAN} fes_class_t;
endpackage

/* File: test/fes_cpu_model.sv */
`timescale 1ns/100ps
// Pipeline side that issues decoded coprocessor instructions and control moves.
module fes_cpu_model (
   // Clock
   input wire logic clk,
   // Issue side
   output logic issueValid,
   output fes_pkg::fes_op_t issueOp,
   output logic [4:0] issueFmt,
   output logic [31:0] issueOperand,
   output logic [5:0] issueExc,
   output logic issueDenormResult,
   output logic issueCompareTrue,
   // Control moves
   output logic ctrlWrite,
   output logic [31:0] ctrlWriteData
);
   import fes_pkg::*;
   initial begin
      issueValid = 1'b0;
      issueOp = OP_NONE;
      issueFmt = 5'h00;
      issueOperand = 32'h0000_0000;
      issueExc = 6'h00;
      issueDenormResult = 1'b0;
      issueCompareTrue = 1'b0;
      ctrlWrite = 1'b0;
      ctrlWriteData = 32'h0000_0000;
   end
   // Every instruction is one aligned 32-bit word; only its decoded fields travel here.
   task automatic issue(input fes_op_t o, input logic [4:0] f, input logic [5:0] e = 6'h00,
         input logic [31:0] v = 32'h0000_0000, input logic dn = 1'b0, input logic ct = 1'b0);
      @(posedge clk);
      issueValid <= 1'b1;
      issueOp <= o;
      issueFmt <= f;
      issueExc <= e;
      issueOperand <= v;
      issueDenormResult <= dn;
      issueCompareTrue <= ct;
      @(posedge clk);
      issueValid <= 1'b0;
      // Released format and operand fields show garbage so a design cannot lean on stale values.
      issueFmt <= ~f;
      issueOperand <= ~v;
      #1;
   endtask
   // Callers clear enabled cause bits first, except where a trap is wanted.
   task automatic write(input logic [31:0] d);
      @(posedge clk);
      ctrlWrite <= 1'b1;
      ctrlWriteData <= d;
      @(posedge clk);
      ctrlWrite <= 1'b0;
      ctrlWriteData <= ~d;
      #1;
   endtask
endmodule // fes_cpu_model

/* File: test/fes_exception_unit_tb.sv */
`timescale 1ns/100ps
module fes_exception_unit_tb;
   import fes_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic issueValid, issueDenormResult, issueCompareTrue, ctrlWrite;
   fes_op_t issueOp;
   logic [4:0] issueFmt;
   logic [5:0] issueExc;
   logic [31:0] issueOperand, ctrlWriteData, csrReadData;
   logic fpTrap, resultWrite, unimplTrap, branchTaken, flushToZero, operandSigNan;
   logic [1:0] roundMode;
   int n_fail = 0;
   int total_checks = 0;
   fes_op_t uOp [14] = '{OP_ARITH, OP_ABS, OP_MOVE, OP_NEG, OP_SQRT, OP_COMPARE,
      OP_CVT_DOUBLE, OP_CVT_LONG, OP_ROUND_LONG, OP_CVT_SINGLE, OP_CVT_WORD,
      OP_LOAD_DWORD, OP_STORE_DWORD, OP_MOVE_DWORD};
   logic [4:0] uFmt [14] = '{FMT_DOUBLE, FMT_DOUBLE, FMT_LONG, FMT_DOUBLE, FMT_WORD,
      FMT_DOUBLE, FMT_SINGLE, FMT_SINGLE, FMT_SINGLE, FMT_DOUBLE, FMT_LONG,
      FMT_SINGLE, FMT_SINGLE, FMT_SINGLE};
   always #20 clk = ~clk;
   fes_cpu_model i_cpu (.clk, .issueValid, .issueOp, .issueFmt, .issueOperand, .issueExc,
      .issueDenormResult, .issueCompareTrue, .ctrlWrite, .ctrlWriteData);
   fes_exception_unit i_dut (.clk, .rstn, .issueValid, .issueOp, .issueFmt, .issueOperand,
      .issueExc, .issueDenormResult, .issueCompareTrue, .ctrlWrite, .ctrlWriteData,
      .csrReadData, .fpTrap, .resultWrite, .unimplTrap, .branchTaken, .roundMode,
      .flushToZero, .operandSigNan);
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // The register copy lags its update by one cycle.
   task automatic rd(input logic [31:0] exp);
      @(posedge clk);
      #1;
      chk("csrReadData", csrReadData, exp);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rd(32'h0000_0000);
      i_cpu.write(32'hffff_ffff);
      chk("fpTrap", fpTrap, 1);
      rd(32'h0183_ffff);
      chk("flushToZero", flushToZero, 1);
      for (int i = 0; i < 4; i++) begin
         i_cpu.write(i);
         rd(i);
         chk("roundMode", roundMode, i);
      end
      $display("test control done");
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h05);
      chk("resultWrite", resultWrite, 1);
      // Rounding field still holds 3 from the last loop pass.
      rd(32'h0000_5017);
      i_cpu.issue(OP_LOAD_WORD, FMT_SINGLE);
      i_cpu.issue(OP_MOVE_WORD, FMT_SINGLE);
      chk("fpTrap", fpTrap, 0);
      rd(32'h0000_5017);
      i_cpu.issue(OP_ARITH, FMT_SINGLE);
      rd(32'h0000_0017);
      i_cpu.write(32'h0000_0814);
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h10);
      chk("fpTrap", fpTrap, 1);
      chk("resultWrite", resultWrite, 0);
      rd(32'h0001_0814);
      $display("test flags done");
      i_cpu.write(32'h0000_0000);
      for (int i = 0; i < 14; i++) begin
         i_cpu.issue(uOp[i], uFmt[i]);
         chk("unimplTrap", unimplTrap, 1);
         chk("fpTrap", fpTrap, 1);
         rd(32'h0002_0000);
      end
      $display("test unimplemented done");
      i_cpu.issue(OP_COMPARE, FMT_WORD, 6'h00, 32'h0000_0000, 1'b0, 1'b1);
      chk("unimplTrap", unimplTrap, 0);
      rd(32'h0080_0000);
      i_cpu.issue(OP_BRANCH, 5'h01);
      chk("branchTaken", branchTaken, 1);
      i_cpu.issue(OP_BRANCH, 5'h00);
      chk("branchTaken", branchTaken, 0);
      i_cpu.issue(OP_COMPARE, FMT_SINGLE);
      rd(32'h0000_0000);
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h00, 32'h7fc0_0000);
      chk("operandSigNan", operandSigNan, 1);
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h00, 32'h7f80_0001);
      chk("operandSigNan", operandSigNan, 0);
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h00, 32'hff80_0000);
      chk("operandSigNan", operandSigNan, 0);
      $display("test compare done");
      i_cpu.write(32'h0100_0000);
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h00, 32'h0000_0000, 1'b1);
      chk("unimplTrap", unimplTrap, 0);
      rd(32'h0100_0000);
      i_cpu.write(32'hfe7c_0000);
      rd(32'h0000_0000);
      i_cpu.issue(OP_ARITH, FMT_SINGLE, 6'h00, 32'h0000_0000, 1'b1);
      chk("unimplTrap", unimplTrap, 1);
      $display("test flush done");
      test_done();
   end
endmodule // fes_exception_unit_tb
